/* hw/dcb_defines.svh */
// Register offsets, write masks, reset values and field positions
`ifndef DCB_DEFINES_SVH
`define DCB_DEFINES_SVH

`define DCB_OFF_CTRL      7'h56
`define DCB_OFF_FILT      7'h57
`define DCB_OFF_GAIN      7'h58
`define DCB_OFF_THRESH    7'h59
`define DCB_OFF_RSVD_A    7'h5A
`define DCB_OFF_RSVD_B    7'h5B
`define DCB_OFF_DEV       7'h5C
`define DCB_OFF_AFC       7'h5D
`define DCB_OFF_SHIFT     7'h5E
`define DCB_OFF_COEF      7'h5F

`define DCB_RST_CTRL      8'h50
`define DCB_RST_FILT      8'h04
`define DCB_RST_GAIN      8'h01
`define DCB_RST_THRESH    8'h10
`define DCB_RST_DEV       8'h18
`define DCB_RST_AFC       8'h0B
`define DCB_RST_SHIFT     8'h00
`define DCB_RST_COEF      8'h07

`define DCB_MSK_CTRL      8'hDF
`define DCB_MSK_FILT      8'h37
`define DCB_MSK_GAIN      8'h07
`define DCB_MSK_FULL      8'hFF
`define DCB_MSK_SHIFT     8'h07

`define DCB_BIT_WIDE      7
`define DCB_BIT_IQINV     6
`define DCB_BIT_RSVD      5
`define DCB_BIT_TLIM      4
`define DCB_BIT_THOLD     3
`define DCB_BIT_ALIMOFF   2
`define DCB_BIT_AHOLD     1
`define DCB_BIT_AOFF      0
`define DCB_AVG_MSB       5
`define DCB_AVG_LSB       4
`define DCB_BWC_MSB       2
`define DCB_BWC_LSB       0

`endif

/* hw/dcb_pkg.sv */
// Types shared by the demodulator configuration bank
package dcb_pkg;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } dcb_reg_req_s;

   typedef struct packed {
      logic             valid;
      logic signed [7:0] i;
      logic signed [7:0] q;
   } dcb_iq_s;

   typedef struct packed {
      logic             valid;
      logic signed [7:0] value;
   } dcb_smp_s;

   typedef struct packed {
      logic [2:0] num;
      logic [9:0] den;
   } dcb_bwf_s;

   typedef struct packed {
      logic       filter_wide_active;
      logic [7:0] eff_bw;
      logic       timing_lim_on;
      logic       timing_freeze;
      logic       afc_limit_en;
      logic       afc_run;
      logic [7:0] afc_limit_value;
      logic [7:0] dev_range;
      logic [7:0] fsk_thresh;
      logic [3:0] gain_x2;
      dcb_bwf_s   bw_factor;
      logic [2:0] pll_shift;
      logic [7:0] pll_coef;
   } dcb_cfg_s;

endpackage

/* hw/dcb_out_average.sv */
// Block averaging of demodulator output over 1, 2, 4 or 8 samples
`timescale 1ns/1ps
`default_nettype none

module dcb_out_average (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            ce,
   input  wire logic [1:0]      avg_sel,
   input  wire dcb_pkg::dcb_smp_s smp_in,
   output var  dcb_pkg::dcb_smp_s smp_out
);
   import dcb_pkg::*;

   logic        [2:0]  count_r;
   logic signed [10:0] acc_r;
   logic signed [10:0] sum;
   logic        [2:0]  last_cnt;
   logic signed [10:0] avg;

   always_comb begin
      last_cnt = 3'((4'h1 << avg_sel) - 4'h1);
      sum      = acc_r + 11'(smp_in.value);
      avg      = sum >>> avg_sel;
   end

   // Accumulate a window, emit one averaged sample per window
   always_ff @(posedge clk) begin
      if (rst) begin
         count_r <= 3'h0;
         acc_r   <= 11'sh000;
         smp_out <= '0;
      end else if (ce) begin
         smp_out.valid <= 1'b0;
         if (smp_in.valid) begin
            if (count_r >= last_cnt) begin // RL8
               count_r       <= 3'h0;
               acc_r         <= 11'sh000;
               smp_out.valid <= 1'b1;
               smp_out.value <= avg[7:0];
            end else begin
               count_r <= count_r + 3'h1;
               acc_r   <= sum;
            end
         end
      end
   end

   a_avg_bypass : assert property (@(posedge clk) disable iff (rst) // RL8
      (ce && smp_in.valid && avg_sel == 2'h0)
      |=> (smp_out.valid && smp_out.value == $past(smp_in.value)))
      else $error("no-averaging mode did not pass the sample");

   a_avg_pair : assert property (@(posedge clk) disable iff (rst) // RL8
      (ce && avg_sel == 2'h1 && smp_in.valid && count_r == 3'h0)
      |=> !smp_out.valid)
      else $error("two-sample averaging emitted after one sample");

endmodule // dcb_out_average

`default_nettype wire

/* hw/dcb_config_bank.sv */
// Demodulator configuration register group and derived controls
//
// What this block does
// RL1 - Wide-before-sync doubles channel filter bandwidth until sync, else programmed.
// RL2 - I/Q invert bit flips the I/Q relation into the demodulator; resets 1.
// RL3 - Timing limiter bit enables symbol timing loop limiter; resets to 1.
// RL4 - Timing hold bit freezes symbol timing after frame delimiter detection.
// RL5 - AFC limiter applied when limiter-off bit is 0, unlimited when 1.
// RL6 - AFC hold bit stops frequency correction after frame delimiter detection.
// RL7 - AFC disable bit turns off frequency correction entirely.
// RL8 - Averaging field selects none, two, four or eight output samples.
// RL9 - Bandwidth code picks factor of master clock over eight.
// RL10 - Demodulator gain equals gain setting plus one, halved.
// RL11 - Eight-bit 4FSK threshold drives symbol decision; resets to 0x10.
// RL12 - Deviation range register passed to demodulator as programmed value.
// RL13 - AFC tracking range register passed to demodulator as programmed.
// RL14 - AFC tracking range used only while limiter-off bit is zero.
// RL15 - Three-bit PLL correction shift field, resets to zero.
// RL16 - Eight-bit PLL correction coefficient, resets to 0x07.
// RL17 - Host should program ranges with recommended initialization values.
// RL18 - Frame-delimiter pulse triggers timing hold, AFC hold and end widening.
// RL19 - Reserved bits read reset value, ignore writes; fields read back.
`timescale 1ns/1ps
`default_nettype none
`include "dcb_defines.svh"

module dcb_config_bank (
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  ce,
   input  wire logic                  page_sel,
   input  wire dcb_pkg::dcb_reg_req_s reg_req,
   output var  logic [7:0]            reg_rdata,
   input  wire logic [6:0]            channel_filter_bw_setting,
   input  wire logic                  rx_restart,
   input  wire logic                  sof_detected,
   input  wire dcb_pkg::dcb_iq_s      iq_in,
   output var  dcb_pkg::dcb_iq_s      iq_out,
   input  wire dcb_pkg::dcb_smp_s     demod_in,
   output var  dcb_pkg::dcb_smp_s     demod_avg,
   output var  dcb_pkg::dcb_cfg_s     cfg
);
   import dcb_pkg::*;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [7:0] demod_control_flags_r;
   logic [7:0] demod_filter_select_r;
   logic [7:0] demod_gain_select_r;
   logic [7:0] four_level_threshold_r;
   logic [7:0] rx_deviation_range_r;
   logic [7:0] afc_tracking_range_r;
   logic [7:0] pll_corr_shift_adjust_r;
   logic [7:0] pll_afc_coefficient_r;
   logic       synced_r;
   logic [7:0] eff_bw_r;
   dcb_bwf_s   bw_factor_r;
   logic       wr_hit;
   logic       rd_hit;
   logic [7:0] rdata_nxt;
   logic       filter_wide_before_sync;
   logic       iq_swap_enable;
   logic       timing_loop_limiter_on;
   logic       timing_hold_after_frame;
   logic       freq_corr_limiter_off;
   logic       freq_corr_hold_after_frame;
   logic       freq_corr_disable;
   logic [1:0] output_averaging_select;
   logic [2:0] demod_bandwidth_code;
   logic [2:0] demod_gain_code;
   logic [7:0] q_neg;

   assign wr_hit = ce && page_sel && reg_req.wr;
   assign rd_hit = ce && page_sel && reg_req.rd;

   // Field views of the stored registers
   assign filter_wide_before_sync    =
      demod_control_flags_r[`DCB_BIT_WIDE];
   assign iq_swap_enable             =
      demod_control_flags_r[`DCB_BIT_IQINV];
   assign timing_loop_limiter_on     =
      demod_control_flags_r[`DCB_BIT_TLIM];
   assign timing_hold_after_frame    =
      demod_control_flags_r[`DCB_BIT_THOLD];
   assign freq_corr_limiter_off      =
      demod_control_flags_r[`DCB_BIT_ALIMOFF];
   assign freq_corr_hold_after_frame =
      demod_control_flags_r[`DCB_BIT_AHOLD];
   assign freq_corr_disable          =
      demod_control_flags_r[`DCB_BIT_AOFF];
   assign output_averaging_select    =
      demod_filter_select_r[`DCB_AVG_MSB:`DCB_AVG_LSB];
   assign demod_bandwidth_code       =
      demod_filter_select_r[`DCB_BWC_MSB:`DCB_BWC_LSB];
   assign demod_gain_code            = demod_gain_select_r[2:0];

   // Register writes, reserved bits masked off
   always_ff @(posedge clk) begin
      if (rst) begin
         demod_control_flags_r  <= `DCB_RST_CTRL;   // RL2 RL3
         demod_filter_select_r  <= `DCB_RST_FILT;
         demod_gain_select_r    <= `DCB_RST_GAIN;
         four_level_threshold_r <= `DCB_RST_THRESH; // RL11
         rx_deviation_range_r   <= `DCB_RST_DEV;
         afc_tracking_range_r   <= `DCB_RST_AFC;
         pll_corr_shift_adjust_r <= `DCB_RST_SHIFT;  // RL15
         pll_afc_coefficient_r  <= `DCB_RST_COEF;   // RL16
      end else if (wr_hit) begin
         case (reg_req.addr)
            `DCB_OFF_CTRL:
               demod_control_flags_r  <= reg_req.wdata & `DCB_MSK_CTRL;  // RL19
            `DCB_OFF_FILT:
               demod_filter_select_r  <= reg_req.wdata & `DCB_MSK_FILT;  // RL19
            `DCB_OFF_GAIN:
               demod_gain_select_r    <= reg_req.wdata & `DCB_MSK_GAIN;  // RL19
            `DCB_OFF_THRESH:
               four_level_threshold_r <= reg_req.wdata;
            `DCB_OFF_DEV:
               rx_deviation_range_r   <= reg_req.wdata;
            `DCB_OFF_AFC:
               afc_tracking_range_r   <= reg_req.wdata;
            `DCB_OFF_SHIFT:
               pll_corr_shift_adjust_r <= reg_req.wdata & `DCB_MSK_SHIFT; // RL19
            `DCB_OFF_COEF:
               pll_afc_coefficient_r  <= reg_req.wdata;
            default: begin
            end
         endcase
      end
   end

   // Read mux; reserved and unmapped offsets read zero
   always_comb begin
      case (reg_req.addr)
         `DCB_OFF_CTRL:   rdata_nxt = demod_control_flags_r;  // RL19
         `DCB_OFF_FILT:   rdata_nxt = demod_filter_select_r;
         `DCB_OFF_GAIN:   rdata_nxt = demod_gain_select_r;
         `DCB_OFF_THRESH: rdata_nxt = four_level_threshold_r;
         `DCB_OFF_DEV:    rdata_nxt = rx_deviation_range_r;
         `DCB_OFF_AFC:    rdata_nxt = afc_tracking_range_r;
         `DCB_OFF_SHIFT:  rdata_nxt = pll_corr_shift_adjust_r;
         `DCB_OFF_COEF:   rdata_nxt = pll_afc_coefficient_r;
         default:         rdata_nxt = 8'h00;                  // RL19
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else if (rd_hit) begin
         reg_rdata <= rdata_nxt;
      end
   end

   // Sync tracking: a new hunt clears it, the delimiter pulse sets it
   always_ff @(posedge clk) begin
      if (rst) begin
         synced_r <= 1'b0;
      end else if (ce) begin
         if (sof_detected) begin
            synced_r <= 1'b1; // RL18
         end else if (rx_restart) begin
            synced_r <= 1'b0;
         end
      end
   end

   // Effective channel filter bandwidth and demodulator bandwidth factor
   always_ff @(posedge clk) begin
      if (rst) begin
         eff_bw_r    <= 8'h00;
         bw_factor_r <= '0;
      end else if (ce) begin
         if (filter_wide_before_sync && !synced_r) begin
            eff_bw_r <= {channel_filter_bw_setting, 1'b0}; // RL1
         end else begin
            eff_bw_r <= {1'b0, channel_filter_bw_setting}; // RL1
         end
         case (demod_bandwidth_code) // RL9
            3'h0:    bw_factor_r <= '{num: 3'h1, den: 10'h078};
            3'h1:    bw_factor_r <= '{num: 3'h1, den: 10'h064};
            3'h2:    bw_factor_r <= '{num: 3'h7, den: 10'h258};
            3'h3:    bw_factor_r <= '{num: 3'h1, den: 10'h04B};
            3'h4:    bw_factor_r <= '{num: 3'h3, den: 10'h0C8};
            3'h5:    bw_factor_r <= '{num: 3'h1, den: 10'h03C};
            default: bw_factor_r <= '{num: 3'h1, den: 10'h01E};
         endcase
      end
   end

   // I/Q path into the demodulator, Q negated with saturation while invert is set
   assign q_neg = (iq_in.q == 8'sh80) ? 8'sh7F : 8'(-iq_in.q);

   always_ff @(posedge clk) begin
      if (rst) begin
         iq_out <= '0;
      end else if (ce) begin
         iq_out.valid <= iq_in.valid;
         if (iq_in.valid) begin
            iq_out.i <= iq_in.i;
            iq_out.q <= iq_swap_enable ? q_neg : iq_in.q; // RL2
         end
      end
   end

   // Configuration and derived controls for the demodulator
   always_comb begin
      cfg                    = '0;
      cfg.filter_wide_active = filter_wide_before_sync && !synced_r; // RL1
      cfg.eff_bw             = eff_bw_r;
      cfg.timing_lim_on      = timing_loop_limiter_on; // RL3
      cfg.timing_freeze      = timing_hold_after_frame && synced_r; // RL4
      cfg.afc_limit_en       = !freq_corr_limiter_off; // RL5
      cfg.afc_run            = !freq_corr_disable &&
         !(freq_corr_hold_after_frame && synced_r); // RL6 RL7
      cfg.afc_limit_value    = freq_corr_limiter_off ?
         8'h00 : afc_tracking_range_r; // RL13 RL14
      cfg.dev_range          = rx_deviation_range_r; // RL12
      cfg.fsk_thresh         = four_level_threshold_r; // RL11
      cfg.gain_x2            = {1'b0, demod_gain_code} + 4'h1; // RL10
      cfg.bw_factor          = bw_factor_r;
      cfg.pll_shift          = pll_corr_shift_adjust_r[2:0]; // RL15
      cfg.pll_coef           = pll_afc_coefficient_r; // RL16
   end

   dcb_out_average u_avg (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .avg_sel (output_averaging_select),
      .smp_in  (demod_in),
      .smp_out (demod_avg)
   );

   a_wide_double : assert property ( // RL1
      (ce && filter_wide_before_sync && !synced_r)
      |=> (eff_bw_r == {$past(channel_filter_bw_setting), 1'b0}))
      else $error("bandwidth not doubled before sync");

   a_sof_ends_wide : assert property ( // RL18
      (ce && sof_detected) |=> (!cfg.filter_wide_active ##1 1'b1))
      else $error("widening survived the delimiter pulse");

   a_restart_widens : assert property ( // RL1
      (ce && rx_restart && !sof_detected && !wr_hit &&
       filter_wide_before_sync) |=> cfg.filter_wide_active)
      else $error("widening not restored by a new hunt");

   a_iq_invert : assert property ( // RL2
      (ce && iq_in.valid && iq_swap_enable && iq_in.q != 8'sh80)
      |=> (iq_out.q == -$past(iq_in.q)))
      else $error("Q not negated while invert set");

   a_iq_pass : assert property ( // RL2
      (ce && iq_in.valid && !iq_swap_enable)
      |=> (iq_out.q == $past(iq_in.q) && iq_out.i == $past(iq_in.i)))
      else $error("Q altered while invert clear");

   a_timing_hold : assert property ( // RL4
      (ce && timing_hold_after_frame && sof_detected && !wr_hit)
      |=> cfg.timing_freeze)
      else $error("timing not frozen after delimiter");

   a_afc_hold : assert property ( // RL6
      (ce && freq_corr_hold_after_frame && sof_detected && !wr_hit)
      |=> !cfg.afc_run)
      else $error("AFC still running after delimiter in hold");

   a_afc_disable : assert property ( // RL7
      (wr_hit && reg_req.addr == `DCB_OFF_CTRL && reg_req.wdata[0])
      |=> !cfg.afc_run)
      else $error("AFC runs after disable written");

   a_afc_range_gate : assert property ( // RL5 RL14
      (cfg.afc_limit_en != freq_corr_limiter_off) and
      (freq_corr_limiter_off |-> cfg.afc_limit_value == 8'h00) and
      (!freq_corr_limiter_off |-> cfg.afc_limit_value == afc_tracking_range_r))
      else $error("tracking range used with limiter off");

   a_bw_top_codes : assert property ( // RL9
      (ce && demod_bandwidth_code[2:1] == 2'h3)
      |=> (bw_factor_r.num == 3'h1 && bw_factor_r.den == 10'h01E))
      else $error("codes 6 and 7 not mapped to one thirtieth");

   a_write_readback : assert property ( // RL19
      (wr_hit && reg_req.addr == `DCB_OFF_THRESH)
      ##1 (rd_hit && reg_req.addr == `DCB_OFF_THRESH && !wr_hit)
      |=> (reg_rdata == $past(reg_req.wdata, 2)))
      else $error("threshold read back differs from write");

   a_reserved_zero : assert property ( // RL19
      (rd_hit && reg_req.addr == `DCB_OFF_CTRL)
      |=> (reg_rdata[`DCB_BIT_RSVD] == 1'b0))
      else $error("reserved control bit read nonzero");

   a_gain_value : assert property ( // RL10
      (wr_hit && reg_req.addr == `DCB_OFF_GAIN)
      |=> (cfg.gain_x2 == {1'b0, $past(reg_req.wdata[2:0])} + 4'h1))
      else $error("gain not setting plus one");

   a_ce_freeze : assert property ( // RL19
      !ce |=> ($stable(reg_rdata) && $stable(synced_r) &&
               $stable(demod_control_flags_r) && $stable(eff_bw_r)))
      else $error("state moved while clock enable low");

endmodule // dcb_config_bank

`default_nettype wire

/* test/dcb_host_model.sv */
// Host processor model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none

module dcb_host_model (
   input  wire logic                  clk,
   input  wire logic [7:0]            rdata,
   output var  dcb_pkg::dcb_reg_req_s req,
   output var  logic                  page_sel
);
   import dcb_pkg::*;

   initial begin
      req = '0;
      page_sel = 1'b1;
   end

   task automatic set_page(input logic p);
      @(negedge clk);
      page_sel = p;
   endtask

   // Held over one rising edge, then released with scrambled lines
   task automatic write(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      req.addr = a;
      req.wdata = d;
      req.wr = 1'b1;
      @(negedge clk);
      req.wr = 1'b0;
      req.addr = ~a;
      req.wdata = ~d;
   endtask

   task automatic read(input logic [6:0] a, output logic [7:0] d);
      @(negedge clk);
      req.addr = a;
      req.rd = 1'b1;
      @(negedge clk);
      req.rd = 1'b0;
      req.addr = ~a;
      d = rdata;
   endtask

   // Start-up values for both range registers
   task automatic init_ranges(input logic [7:0] dv, input logic [7:0] af);
      write(7'h5C, dv);
      write(7'h5D, af);
   endtask
endmodule // dcb_host_model

`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the demodulator configuration bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
   fail_count++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end

module tb_top;
   import dcb_pkg::*;
   logic         clk = 1'b0;
   logic         rst = 1'b1;
   logic         ce = 1'b1;
   logic [6:0]   bw = 7'h25;
   logic         restart = 1'b0;
   logic         sof = 1'b0;
   dcb_iq_s      iq_i = '0;
   dcb_iq_s      iq_o;
   dcb_smp_s     dm_i = '0;
   dcb_smp_s     dm_o;
   dcb_cfg_s     cfg;
   dcb_reg_req_s req;
   logic         page;
   logic [7:0]   rdata;
   logic [7:0]   rd;
   logic [7:0]   rnd = 8'h3C;
   int           fail_count = 0;
   int           samples_checked = 0;
   int           m[10];
   int           rmsk[10] = '{8'hDF,8'h37,8'h07,8'hFF,0,0,8'hFF,8'hFF,8'h07,8'hFF};
   int           rval[10] = '{8'h50,8'h04,8'h01,8'h10,0,0,8'h18,8'h0B,0,8'h07};
   int           fnum[8] = '{1,1,7,1,3,1,1,1};
   int           fden[8] = '{120,100,600,75,200,60,30,30};

   always #12.5 clk = ~clk;

   dcb_config_bank dcb_config_bank_inst (
      .clk                       (clk),
      .rst                       (rst),
      .ce                        (ce),
      .page_sel                  (page),
      .reg_req                   (req),
      .reg_rdata                 (rdata),
      .channel_filter_bw_setting (bw),
      .rx_restart                (restart),
      .sof_detected              (sof),
      .iq_in                     (iq_i),
      .iq_out                    (iq_o),
      .demod_in                  (dm_i),
      .demod_avg                 (dm_o),
      .cfg                       (cfg)
   );

   dcb_host_model host (
      .clk      (clk),
      .rdata    (rdata),
      .req      (req),
      .page_sel (page)
   );

   function automatic logic [7:0] next_rnd();
      rnd = {rnd[6:0], rnd[7] ^ rnd[5] ^ rnd[4] ^ rnd[3]};
      return rnd;
   endfunction

   task automatic wr(input int a, input logic [7:0] d);
      host.write(7'(a), d);
      if (a >= 'h56 && a <= 'h5F) m[a-'h56] = d & rmsk[a-'h56];
   endtask

   task automatic rchk(input int a);
      int e;
      e = (a >= 'h56 && a <= 'h5F) ? m[a-'h56] : 0;
      host.read(7'(a), rd);
      `CHK("readback", e, rd)
   endtask

   task automatic cfg_chk();
      `CHK("lim", m[0][4], cfg.timing_lim_on)
      `CHK("afc_en", !m[0][2], cfg.afc_limit_en)
      `CHK("afc_run", !m[0][0], cfg.afc_run)
      `CHK("afc_val", m[0][2] ? 0 : m[7], cfg.afc_limit_value)
      `CHK("dev", m[6], cfg.dev_range)
      `CHK("thr", m[3], cfg.fsk_thresh)
      `CHK("gain", (m[2] & 7) + 1, cfg.gain_x2)
      `CHK("shift", m[8], cfg.pll_shift)
      `CHK("coef", m[9], cfg.pll_coef)
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #500000;
      fail_count++;
      stop_test();
   end

   initial begin
      int a;
      int e;
      int n;
      logic done;
      int sq[$];
      repeat (6) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 10; i++) m[i] = rval[i];
      for (int i = 'h55; i <= 'h60; i++) rchk(i);
      cfg_chk();
      $display("test reset values done");
      host.init_ranges(8'h2A, 8'h13);
      m[6] = 'h2A;
      m[7] = 'h13;
      for (int i = 0; i < 40; i++) begin
         a = 'h56 + next_rnd() % 12;
         wr(a, next_rnd());
         rchk(a);
         cfg_chk();
      end
      ce = 1'b0;
      host.write(7'h59, 8'hEE);
      ce = 1'b1;
      host.set_page(1'b0);
      host.write(7'h59, 8'hEE);
      host.set_page(1'b1);
      rchk('h59);
      $display("test register access done");
      wr('h56, 8'h8A);
      `CHK("wide", 1'b1, cfg.filter_wide_active)
      @(negedge clk);
      `CHK("eff_bw", int'(bw) * 2, cfg.eff_bw)
      sof = 1'b1;
      @(negedge clk);
      sof = 1'b0;
      `CHK("wide", 1'b0, cfg.filter_wide_active)
      `CHK("freeze", 1'b1, cfg.timing_freeze)
      `CHK("afc_run", 1'b0, cfg.afc_run)
      @(negedge clk);
      `CHK("eff_bw", int'(bw), cfg.eff_bw)
      wr('h56, 8'h00);
      `CHK("freeze", 1'b0, cfg.timing_freeze)
      `CHK("afc_run", 1'b1, cfg.afc_run)
      wr('h56, 8'h8A);
      restart = 1'b1;
      @(negedge clk);
      restart = 1'b0;
      `CHK("wide", 1'b1, cfg.filter_wide_active)
      `CHK("freeze", 1'b0, cfg.timing_freeze)
      `CHK("afc_run", 1'b1, cfg.afc_run)
      $display("test frame sync done");
      for (int k = 0; k < 2; k++) begin
         wr('h56, k ? 8'h40 : 8'h00);
         iq_i.valid = 1'b1;
         for (int s = 0; s < 6; s++) begin
            iq_i.i = next_rnd();
            iq_i.q = (s == 0) ? 8'h80 : next_rnd();
            n = int'(iq_i.q);
            e = k ? ((n == -128) ? 127 : -n) : n;
            @(negedge clk);
            `CHK("iq_v", 1'b1, iq_o.valid)
            `CHK("iq_i", iq_i.i, iq_o.i)
            `CHK("iq_q", e, iq_o.q)
         end
         iq_i.valid = 1'b0;
      end
      $display("test iq invert done");
      for (int k = 0; k < 4; k++) begin
         wr('h57, 8'(k << 4));
         n = 0;
         do begin
            dm_i.valid = 1'b1;
            dm_i.value = next_rnd();
            @(negedge clk);
            dm_i.valid = 1'b0;
            done = dm_o.valid;
            @(negedge clk);
            n++;
         end while (done !== 1'b1 && n < 9);
         sq.delete();
         dm_i.valid = 1'b1;
         for (int s = 0; s < (1 << k); s++) begin
            dm_i.value = next_rnd();
            sq.push_back(int'(dm_i.value));
            @(negedge clk);
         end
         dm_i.valid = 1'b0;
         e = sq.sum() >>> k;
         `CHK("avg_v", 1'b1, dm_o.valid)
         `CHK("avg", e, dm_o.value)
      end
      $display("test averaging done");
      for (int c = 0; c < 8; c++) begin
         wr('h57, 8'(c));
         @(negedge clk);
         `CHK("bw_num", fnum[c], cfg.bw_factor.num)
         `CHK("bw_den", fden[c], cfg.bw_factor.den)
      end
      $display("test bandwidth codes done");
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      for (int i = 0; i < 10; i++) m[i] = rval[i];
      for (int i = 'h56; i <= 'h5F; i++) rchk(i);
      cfg_chk();
      `CHK("wide", 1'b0, cfg.filter_wide_active)
      `CHK("eff_bw", int'(bw), cfg.eff_bw)
      `CHK("bw_num", fnum[4], cfg.bw_factor.num)
      `CHK("bw_den", fden[4], cfg.bw_factor.den)
      $display("test mid-run reset done");
      stop_test();
   end
endmodule // tb_top

`default_nettype wire
